// [logic/ccf_regs.svh]
// field positions, reset values for the condition code flags block
`ifndef CCF_REGS_SVH
`define CCF_REGS_SVH
`define CCF_BIT_CARRY      0
`define CCF_BIT_ZERO       1
`define CCF_BIT_NEG        2
`define CCF_BIT_PRIO_LOW   3
`define CCF_BIT_HALF       4
`define CCF_BIT_PRIO_HIGH  5
`define CCF_RESET_VALUE    8'hE8
`define CCF_FIXED_ONES     8'hC0
`define CCF_SP_RESET       16'h01FF
`define CCF_SP_HIGH_BYTE   8'h01
`endif

// [logic/ccf_pkg.sv]
// types for the condition code flags block
package ccf_pkg;
  typedef enum logic [3:0] {
    CCF_OP_NONE  = 4'h0,
    CCF_OP_ADD   = 4'h1,
    CCF_OP_LOGIC = 4'h2,
    CCF_OP_SHIFT = 4'h3,
    CCF_OP_SCF   = 4'h4,
    CCF_OP_RCF   = 4'h5,
    CCF_OP_PRIO  = 4'h6,
    CCF_OP_POP   = 4'h7,
    CCF_OP_BITW  = 4'h8,
    CCF_OP_CMP   = 4'h9
  } ccf_op_t;
  typedef enum logic [1:0] {
    CCF_LVL2 = 2'b00,
    CCF_LVL1 = 2'b01,
    CCF_LVL0 = 2'b10,
    CCF_LVL3 = 2'b11
  } ccf_level_t;
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] spLow;
  } ccf_state_t;
endpackage : ccf_pkg

// [logic/ccf_branch_eval.sv]
// branch condition evaluation from the flags
`timescale 1ns/10ps
`default_nettype none
`include "ccf_regs.svh"
module ccf_branch_eval (
  // flags in
  input  wire logic [7:0] flags,
  // condition select and result
  input  wire logic [2:0] condSel,
  input  wire logic       condInvert,
  output logic            condTrue
);
  logic raw;
  always_comb begin
    unique case (condSel)
      3'h0: raw = 1'b1;
      3'h1: raw = flags[`CCF_BIT_HALF];
      3'h2: raw = flags[`CCF_BIT_NEG];
      3'h3: raw = flags[`CCF_BIT_ZERO];
      3'h4: raw = flags[`CCF_BIT_CARRY];
      3'h5: raw = flags[`CCF_BIT_PRIO_HIGH] & flags[`CCF_BIT_PRIO_LOW];
      3'h6: raw = flags[`CCF_BIT_CARRY] | flags[`CCF_BIT_ZERO];
      3'h7: raw = 1'b0;
    endcase
    condTrue = raw ^ condInvert;
  end
endmodule : ccf_branch_eval
`default_nettype wire

// [logic/ccf_flags.sv]
// condition code register and stack pointer reset value
// Function
// - eight-bit flags register holding priority mask and four result flags
// - whole register pushed to and popped from the stack
// - each bit testable alone, bits 5..0 settable alone, others untouched
// - add and add-with-carry set half carry on carry out of bit 3
// - same instructions clear half carry without it; others except pop and bit writes keep it
// - reset gives bits 7..5 and bit 3 set
// - reset loads stack pointer with top of the stack area
// - half carry usable as a relative branch condition
// - negative flag copies result bit 7
// - zero flag set when result is zero, else cleared
// - carry records overflow or borrow; set, cleared, shift and bit-test affect it
// - priority bits 5,3: 10 level0, 01 level1, 00 level2, 11 disabled
`timescale 1ns/10ps
`default_nettype none
`include "ccf_regs.svh"
module ccf_flags (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // alu result path
  input  wire logic                  writeBack,
  input  wire ccf_pkg::ccf_op_t      opKind,
  input  wire logic [7:0]            aluResult,
  input  wire logic                  aluCarry,
  input  wire logic                  aluHalfCarry,
  // priority load from interrupt unit or software
  input  wire ccf_pkg::ccf_level_t   levelIn,
  // single bit access
  input  wire logic                  bitWrite,
  input  wire logic [2:0]            bitSel,
  input  wire logic                  bitValue,
  // pop path and stack pointer
  input  wire logic [7:0]            popData,
  input  wire logic                  spReset,
  input  wire logic                  spLoad,
  input  wire logic [7:0]            spLoadValue,
  // branch test
  input  wire logic [2:0]            condSel,
  input  wire logic                  condInvert,
  output logic                       condTrue,
  // register views
  output logic [7:0]                 condition_flags,
  output logic [7:0]                 pushData,
  output logic [15:0]                stack_pointer_reg,
  output ccf_pkg::ccf_level_t        priorityLevel,
  output logic                       interruptsDisabled,
  output logic                       selectedBit
);
  ccf_pkg::ccf_state_t state_q;
  ccf_pkg::ccf_state_t state_d;
  // result-derived values shared by every op that reports on the result
  logic                resultNeg;
  logic                resultZero;
  // per-bit update request and value from the op; a bit with no request keeps its value
  logic [7:0]          opMask;
  logic [7:0]          opValue;
  // per-bit hit of the single bit access; bits 7..6 cannot be written
  logic [5:0]          bitHit;
  // next flag byte assembled bit by bit
  logic [7:0]          flagsNext;
  assign resultNeg  = aluResult[7];
  assign resultZero = (aluResult == 8'h00);
  // op decode; an op touches the flags only in a write-back cycle
  always_comb begin
    opMask  = 8'h00;
    opValue = 8'h00;
    if (writeBack) begin
      unique case (opKind)
        ccf_pkg::CCF_OP_NONE: begin
        end
        ccf_pkg::CCF_OP_ADD: begin
          opMask[`CCF_BIT_HALF]   = 1'b1;
          opValue[`CCF_BIT_HALF]  = aluHalfCarry;
          opMask[`CCF_BIT_NEG]    = 1'b1;
          opValue[`CCF_BIT_NEG]   = resultNeg;
          opMask[`CCF_BIT_ZERO]   = 1'b1;
          opValue[`CCF_BIT_ZERO]  = resultZero;
          opMask[`CCF_BIT_CARRY]  = 1'b1;
          opValue[`CCF_BIT_CARRY] = aluCarry;
        end
        ccf_pkg::CCF_OP_CMP, ccf_pkg::CCF_OP_SHIFT: begin
          // half carry is left alone: only add and add-with-carry own it
          opMask[`CCF_BIT_NEG]    = 1'b1;
          opValue[`CCF_BIT_NEG]   = resultNeg;
          opMask[`CCF_BIT_ZERO]   = 1'b1;
          opValue[`CCF_BIT_ZERO]  = resultZero;
          opMask[`CCF_BIT_CARRY]  = 1'b1;
          opValue[`CCF_BIT_CARRY] = aluCarry;
        end
        ccf_pkg::CCF_OP_LOGIC: begin
          opMask[`CCF_BIT_NEG]    = 1'b1;
          opValue[`CCF_BIT_NEG]   = resultNeg;
          opMask[`CCF_BIT_ZERO]   = 1'b1;
          opValue[`CCF_BIT_ZERO]  = resultZero;
        end
        ccf_pkg::CCF_OP_BITW: begin
          opMask[`CCF_BIT_CARRY]  = 1'b1;
          opValue[`CCF_BIT_CARRY] = aluCarry;
        end
        ccf_pkg::CCF_OP_SCF: begin
          opMask[`CCF_BIT_CARRY]  = 1'b1;
          opValue[`CCF_BIT_CARRY] = 1'b1;
        end
        ccf_pkg::CCF_OP_RCF: begin
          opMask[`CCF_BIT_CARRY]  = 1'b1;
          opValue[`CCF_BIT_CARRY] = 1'b0;
        end
        ccf_pkg::CCF_OP_PRIO: begin
          opMask[`CCF_BIT_PRIO_HIGH]  = 1'b1;
          opValue[`CCF_BIT_PRIO_HIGH] = levelIn[1];
          opMask[`CCF_BIT_PRIO_LOW]   = 1'b1;
          opValue[`CCF_BIT_PRIO_LOW]  = levelIn[0];
        end
        ccf_pkg::CCF_OP_POP: begin
          opMask  = 8'hFF;
          opValue = popData | `CCF_FIXED_ONES;
        end
        default: begin
        end
      endcase
    end
  end
  // bit writes sit above the op so a same-cycle single bit access is never masked
  for (genvar b = 0; b < 8; b++) begin : g_flag
    if (b >= 6) begin : g_fixed
      // bits 7..6 have no storage and always read one
      assign flagsNext[b] = 1'b1;
    end else begin : g_store
      assign bitHit[b]    = bitWrite && (bitSel == 3'(b));
      assign flagsNext[b] = bitHit[b] ? bitValue :
                            opMask[b] ? opValue[b] : state_q.flags[b];
    end
  end
  always_comb begin
    state_d = state_q;
    if (spReset) begin
      state_d.spLow = 8'(`CCF_SP_RESET);
    end else if (spLoad) begin
      state_d.spLow = spLoadValue;
    end
    // updates land on the write-back edge so the next instruction sees them
    state_d.flags = flagsNext;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '{flags: `CCF_RESET_VALUE, spLow: 8'(`CCF_SP_RESET)};
    end else begin
      state_q <= state_d;
    end
  end
  assign condition_flags    = state_q.flags;
  assign pushData           = state_q.flags;
  assign stack_pointer_reg  = {`CCF_SP_HIGH_BYTE, state_q.spLow};
  assign priorityLevel      = ccf_pkg::ccf_level_t'({state_q.flags[`CCF_BIT_PRIO_HIGH],
                                                     state_q.flags[`CCF_BIT_PRIO_LOW]});
  assign interruptsDisabled = (priorityLevel == ccf_pkg::CCF_LVL3);
  assign selectedBit        = state_q.flags[bitSel];
  ccf_branch_eval u_branch (
    .flags      (state_q.flags),
    .condSel    (condSel),
    .condInvert (condInvert),
    .condTrue   (condTrue)
  );
endmodule : ccf_flags
`default_nettype wire

// [tb/ccf_flags_asserts.sv]
// assertions on the condition code flags ports
`timescale 1ns/10ps
`default_nettype none
module ccf_flags_asserts (
  // clock and reset
  input wire logic             clk,
  input wire logic             reset_n,
  // requests
  input wire logic             writeBack,
  input wire logic             bitWrite,
  input wire ccf_pkg::ccf_op_t opKind,
  input wire logic [7:0]       aluResult,
  input wire logic             aluCarry,
  input wire logic             aluHalfCarry,
  input wire logic [7:0]       popData,
  // views
  input wire logic [7:0]       condition_flags,
  input wire logic [7:0]       pushData,
  input wire logic [15:0]      stack_pointer_reg,
  input wire logic             interruptsDisabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a bit write wins over the op, so those cycles are left out
  wire logic op  = writeBack && !bitWrite;
  wire logic add = op && opKind == ccf_pkg::CCF_OP_ADD;
  wire logic pop = op && opKind == ccf_pkg::CCF_OP_POP;
  wire logic alu = add || op && opKind inside {ccf_pkg::CCF_OP_SHIFT, ccf_pkg::CCF_OP_CMP};
  wire logic nz  = alu || op && opKind == ccf_pkg::CCF_OP_LOGIC;
  fixed_ones_a: assert property (condition_flags[7:6] == 2'b11)
    else $error("top bits dropped");
  push_whole_a: assert property (pushData == condition_flags)
    else $error("push byte differs");
  pop_load_a: assert property (pop |=> condition_flags == ($past(popData) | 8'hC0))
    else $error("pop not loaded");
  half_add_a: assert property (add |=> condition_flags[4] == $past(aluHalfCarry))
    else $error("half carry wrong");
  half_keep_a: assert property (!add && !pop && !bitWrite |=> $stable(condition_flags[4]))
    else $error("half carry moved");
  neg_copy_a: assert property (nz |=> condition_flags[2] == $past(aluResult[7]))
    else $error("negative wrong");
  zero_flag_a: assert property (nz |=> condition_flags[1] == ($past(aluResult) == 8'h00))
    else $error("zero wrong");
  carry_flag_a: assert property (alu |=> condition_flags[0] == $past(aluCarry))
    else $error("carry wrong");
  sp_high_a: assert property (stack_pointer_reg[15:8] == 8'h01)
    else $error("stack page moved");
  int_off_a: assert property (interruptsDisabled == &{condition_flags[5], condition_flags[3]})
    else $error("disable view wrong");
endmodule : ccf_flags_asserts
bind ccf_flags ccf_flags_asserts u_chk (.*);
`default_nettype wire

// [tb/tb_ccf_flags.sv]
// self-checking bench for the condition code flags
`timescale 1ns/10ps
`default_nettype none
module tb_ccf_flags;
  logic clk, reset_n, writeBack, aluCarry, aluHalfCarry, bitWrite, bitValue, spReset;
  logic spLoad, condInvert, condTrue, interruptsDisabled, selectedBit;
  logic [7:0]          aluResult, popData, spLoadValue, condition_flags, pushData, r;
  logic [2:0]          bitSel, condSel;
  logic [15:0]         stack_pointer_reg;
  ccf_pkg::ccf_op_t    opKind;
  ccf_pkg::ccf_level_t levelIn, priorityLevel;
  int                  mismatches = 0, checked = 0;
  // op, result, carry and half carry, flags expected after the edge
  logic [23:0] rows [9] = '{24'h10_03FB, 24'h28_00FD, 24'h30_11F8, 24'h90_02FB,
                            24'h17_F0E8, 24'h8F_F3E9, 24'h50_00E8, 24'h40_00E9, 24'h00_03E9};
  ccf_flags DUT (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // tries every branch code against a truth vector, odd codes inverted
  task automatic sweep_conds(input logic [7:0] flagsExp, input logic [7:0] truth);
    for (int k = 0; k < 8; k++) begin
      condSel    = k[2:0];
      condInvert = k[0];
      @(negedge clk);
      check({condition_flags, condTrue}, {flagsExp, truth[k] ^ k[0]});
    end
  endtask : sweep_conds
  // undefined bits are masked, only the documented ones are held to a value
  task automatic do_reset;
    reset_n = 0;
    repeat (5) @(negedge clk);
    check(condition_flags & 8'hE8, 8'hE8);
    check(stack_pointer_reg, 16'h01FF);
    reset_n = 1;
    $display("reset test done");
  endtask : do_reset
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {writeBack, aluCarry, aluHalfCarry, bitWrite, bitValue, spReset, spLoad, condInvert} = '0;
    {aluResult, popData, spLoadValue, bitSel, condSel} = '0;
    opKind = ccf_pkg::CCF_OP_NONE;
    levelIn = ccf_pkg::CCF_LVL0;
    do_reset();
    writeBack = 1;
    foreach (rows[i]) begin
      opKind = ccf_pkg::ccf_op_t'(rows[i][23:20]);
      {aluResult, aluCarry, aluHalfCarry} = {rows[i][19:12], rows[i][9:8]};
      @(negedge clk);
      check(condition_flags, rows[i][7:0]);
    end
    $display("alu row test done");
    opKind = ccf_pkg::CCF_OP_PRIO;
    for (int i = 0; i < 4; i++) begin
      levelIn = ccf_pkg::ccf_level_t'(i);
      @(negedge clk);
      check({condition_flags[5], condition_flags[3], priorityLevel, interruptsDisabled},
            {i[1:0], i[1:0], i == 3});
    end
    opKind = ccf_pkg::CCF_OP_POP;
    popData = 8'h3F;
    @(negedge clk);
    check(pushData, 8'hFF);
    $display("priority and pop test done");
    // pop stays selected with writeBack low: it must be ignored
    writeBack = 0;
    bitWrite = 1;
    condSel = 3'h1;
    r = 8'hFF;
    // first pass clears bits 0..5, second pass sets them again; 6 and 7 are ignored
    for (int i = 0; i < 16; i++) begin
      bitSel     = i[2:0];
      bitValue   = i[3];
      condInvert = i[0];
      if (i[2:0] < 3'h6) r[i[2:0]] = i[3];
      @(negedge clk);
      check({condition_flags, selectedBit, condTrue}, {r, r[i[2:0]], r[4] ^ i[0]});
    end
    // a bit write beats a same-cycle op; an ignored bit select lets the op through
    writeBack = 1;
    opKind    = ccf_pkg::CCF_OP_RCF;
    bitSel    = 3'h0;
    bitValue  = 1;
    @(negedge clk);
    check(condition_flags, 8'hFF);
    bitSel   = 3'h6;
    bitValue = 0;
    @(negedge clk);
    check(condition_flags, 8'hFE);
    {writeBack, bitWrite} = '0;
    spLoad      = 1;
    spReset     = 1;
    spLoadValue = 8'h20;
    @(negedge clk);
    check(stack_pointer_reg, 16'h01FF);
    spReset = 0;
    @(negedge clk);
    check(stack_pointer_reg, 16'h0120);
    spLoad = 0;
    $display("bit and stack test done");
    do_reset();
    // idle after a mid-run release: the reset value must hold while every code is tried
    sweep_conds(8'hE8, 8'h21);
    writeBack = 1;
    opKind    = ccf_pkg::CCF_OP_ADD;
    {aluResult, aluCarry, aluHalfCarry} = {8'h00, 2'b11};
    @(negedge clk);
    writeBack = 0;
    check(condition_flags, 8'hFB);
    sweep_conds(8'hFB, 8'h7B);
    $display("branch sweep test done");
    wrap_up();
  end
endmodule : tb_ccf_flags
`default_nettype wire
